// file: logic/tcs_fifo.sv
`timescale 1ns/1ps
module tcs_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  // ==========================================================
  logic [W-1:0] store_q [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next, valid_reg, valid_next;
  logic push, pop;

  assign push = in_valid && ready_reg;
  assign pop = valid_reg && out_ready;
  assign in_ready = ready_reg;
  assign out_valid = valid_reg;
  assign out_data = store_q[rd_reg];

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    ready_next = cnt_next != (AW+1)'(DEPTH);
    valid_next = cnt_next != '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store_q[wr_reg] <= in_data;
    end
  end
endmodule

// file: logic/tcs_mem.sv
`timescale 1ns/1ps
module tcs_mem #(
  parameter int W = 10,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] cells_q [2**AW];
  logic [W-1:0] rdata_reg;

  assign rdata = rdata_reg;

  // Read data is registered; a write and a read of the same cell in one
  // cycle returns the old contents.
  always_ff @(posedge clk) begin
    if (we) begin
      cells_q[waddr] <= wdata;
    end
    rdata_reg <= cells_q[raddr];
  end
endmodule

// file: logic/tcs_pkg.sv
package tcs_pkg;

  // ==========================================================
  // Geometry
  // ==========================================================
  localparam int TS_W = 5;
  localparam int ENTRY_ADDR_W = TS_W + 1;
  localparam int FIFO_DEPTH = 16;

  // Interface indices; a sample names the interface it is sent to.
  localparam logic SIDE_NET = 1'b0;
  localparam logic SIDE_DSX = 1'b1;

  // ==========================================================
  // Signaling codes
  // ==========================================================
  localparam logic [3:0] ABCD_ZEROS = 4'h0;
  localparam logic [3:0] ABCD_ONES = 4'hf;
  localparam logic [3:0] ABCD_ALT = 4'h5;
  localparam logic [3:0] ABCD_AB_MASK = 4'hc;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_KHZ = 10000;
  localparam int IDLE_FORCE_MS = 2000;
  localparam int IDLE_FORCE_CYCLES = IDLE_FORCE_MS * CLK_KHZ;
  localparam int TIMER_W = 25;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [4:0] {
    SET_NONE, SET_RBS,
    SET_EM_IDLE, SET_EM_BUSY,
    SET_OFFICE_GND_IDLE, SET_OFFICE_GND_BUSY,
    SET_OFFICE_LOOP_IDLE, SET_OFFICE_LOOP_BUSY,
    SET_STATION_GND_IDLE, SET_STATION_GND_BUSY,
    SET_STATION_LOOP_IDLE, SET_STATION_LOOP_BUSY,
    SET_OFFICE_DIAL_IDLE, SET_OFFICE_DIAL_BUSY,
    SET_STATION_DIAL_IDLE, SET_STATION_DIAL_BUSY,
    SET_PLAR3_IDLE, SET_PLAR3_BUSY,
    SET_PLAR4_IDLE, SET_PLAR4_BUSY,
    SET_ORIG_IDLE, SET_ORIG_BUSY,
    SET_TERM_IDLE, SET_TERM_BUSY,
    SET_USER
  } tcs_setting_e;

  typedef struct packed {
    logic xconn;
    tcs_setting_e code;
    logic [3:0] user_abcd;
  } tcs_entry_s;

  localparam tcs_entry_s ENTRY_RESET = '{1'b0, SET_RBS, 4'h0};

  typedef struct packed {
    logic side;
    logic [TS_W-1:0] ts;
    tcs_entry_s entry;
  } tcs_cfg_s;

  typedef struct packed {
    logic dest;
    logic [TS_W-1:0] ts;
    logic [3:0] abcd;
  } tcs_sample_s;

  typedef struct packed {
    logic dest;
    logic [TS_W-1:0] ts;
    logic [3:0] abcd;
    logic sig_used;
    logic conditioned;
    logic ab_only;
  } tcs_out_s;

  typedef struct packed {
    logic los;
    logic oof;
    logic ais;
    logic d4;
  } tcs_line_s;

endpackage

// file: logic/tcs_signaling.sv
`timescale 1ns/1ps
// Contract
// RL1: Only cross-connected timeslots get conditioning applied.
// RL2: No-signaling setting passes clear channel untouched.
// RL3: Plain robbed-bit forwards bits without alarm.
// RL4: Plain robbed-bit sends all ones during alarm.
// RL5: D4 destination carries only A and B.
// RL6: E&M idle 0000, busy 1111.
// RL7: Office ground-start idle 1111, busy 0101.
// RL8: Office loop-start idle and busy 0101.
// RL9: Station ground-start idle 0101, busy 1111.
// RL10: Station loop-start idle 0101, busy 1111.
// RL11: Office dial-network idle 0000, busy 1111.
// RL12: Station dial-network idle 0000, busy 1111.
// RL13: PLAR D3 idle 0000, busy 1111.
// RL14: PLAR D4 idle 1111, busy 0000.
// RL15: Dial-pulse originate idle 0000, busy 1111.
// RL16: Dial-pulse terminate idle 0000, busy 1111.
// RL17: User setting sends its own four bits.
// RL18: DSX default mirrors network, office/station swapped.
// RL19: Leaving no-signaling loads DSX side default.
// RL20: Alarm declared on loss, out-of-frame or AIS.
// RL21: Alarm forces idle two seconds, then selection.
// RL22: User setting skips the idle phase.
// RL23: Hold code until alarm clears, then forward.
// RL24: Reset setting is plain robbed-bit both sides.
// RL25: Each direction of each timeslot kept apart.
module tcs_signaling #(
  parameter int COND_IDLE_CYCLES = tcs_pkg::IDLE_FORCE_CYCLES,
  parameter int FIFO_DEPTH = tcs_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire tcs_pkg::tcs_line_s [1:0] line_status,
  input wire logic in_valid,
  output logic in_ready,
  input wire tcs_pkg::tcs_sample_s in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output tcs_pkg::tcs_out_s out_sample,
  input wire logic cfg_valid,
  output logic cfg_ready,
  input wire tcs_pkg::tcs_cfg_s cfg,
  output logic [1:0] carrier_group_alarm,
  output logic [1:0] idle_forcing
);
  localparam int SW = $bits(tcs_pkg::tcs_sample_s);
  localparam int EW = $bits(tcs_pkg::tcs_entry_s);
  localparam int AW = tcs_pkg::ENTRY_ADDR_W;
  localparam int TW = tcs_pkg::TIMER_W;
  localparam logic [TW-1:0] IDLE_END = TW'(COND_IDLE_CYCLES);

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_CFG_CHK, ST_CFG_DEF, ST_DATA
  } tcs_state_e;

  // ==========================================================
  // Signaling code tables
  // ==========================================================
  // Code sent during an alarm; force_idle selects the idle code of the
  // setting's family for the first phase of an alarm.
  function automatic logic [3:0] cond_code(
    input tcs_pkg::tcs_setting_e s,
    input logic force_idle
  );
    logic [3:0] c;
    c = tcs_pkg::ABCD_ONES;
    case (s)
      tcs_pkg::SET_EM_IDLE, tcs_pkg::SET_OFFICE_DIAL_IDLE,
      tcs_pkg::SET_STATION_DIAL_IDLE, tcs_pkg::SET_PLAR3_IDLE,
      tcs_pkg::SET_ORIG_IDLE, tcs_pkg::SET_TERM_IDLE: begin
        c = tcs_pkg::ABCD_ZEROS; // RL6 RL11 RL12 RL13 RL15 RL16
      end
      tcs_pkg::SET_EM_BUSY, tcs_pkg::SET_OFFICE_DIAL_BUSY,
      tcs_pkg::SET_STATION_DIAL_BUSY, tcs_pkg::SET_PLAR3_BUSY,
      tcs_pkg::SET_ORIG_BUSY, tcs_pkg::SET_TERM_BUSY: begin
        c = force_idle ? tcs_pkg::ABCD_ZEROS : tcs_pkg::ABCD_ONES;
      end
      tcs_pkg::SET_OFFICE_GND_IDLE: begin
        c = tcs_pkg::ABCD_ONES; // RL7
      end
      tcs_pkg::SET_OFFICE_GND_BUSY: begin
        c = force_idle ? tcs_pkg::ABCD_ONES : tcs_pkg::ABCD_ALT; // RL7
      end
      tcs_pkg::SET_OFFICE_LOOP_IDLE, tcs_pkg::SET_OFFICE_LOOP_BUSY: begin
        c = tcs_pkg::ABCD_ALT; // RL8
      end
      tcs_pkg::SET_STATION_GND_IDLE, tcs_pkg::SET_STATION_LOOP_IDLE: begin
        c = tcs_pkg::ABCD_ALT; // RL9 RL10
      end
      tcs_pkg::SET_STATION_GND_BUSY, tcs_pkg::SET_STATION_LOOP_BUSY: begin
        c = force_idle ? tcs_pkg::ABCD_ALT : tcs_pkg::ABCD_ONES; // RL9 RL10
      end
      tcs_pkg::SET_PLAR4_IDLE: begin
        c = tcs_pkg::ABCD_ONES; // RL14
      end
      tcs_pkg::SET_PLAR4_BUSY: begin
        c = force_idle ? tcs_pkg::ABCD_ONES : tcs_pkg::ABCD_ZEROS; // RL14
      end
      default: begin
        c = tcs_pkg::ABCD_ONES; // RL4
      end
    endcase
    return c;
  endfunction

  // Typical far-side partner of a network-side setting.
  function automatic tcs_pkg::tcs_setting_e dsx_default(
    input tcs_pkg::tcs_setting_e s
  );
    tcs_pkg::tcs_setting_e d;
    d = s;
    case (s) // RL18
      tcs_pkg::SET_OFFICE_GND_IDLE: d = tcs_pkg::SET_STATION_GND_IDLE;
      tcs_pkg::SET_OFFICE_GND_BUSY: d = tcs_pkg::SET_STATION_GND_BUSY;
      tcs_pkg::SET_OFFICE_LOOP_IDLE: d = tcs_pkg::SET_STATION_LOOP_IDLE;
      tcs_pkg::SET_OFFICE_LOOP_BUSY: d = tcs_pkg::SET_STATION_LOOP_BUSY;
      tcs_pkg::SET_STATION_GND_IDLE: d = tcs_pkg::SET_OFFICE_GND_IDLE;
      tcs_pkg::SET_STATION_GND_BUSY: d = tcs_pkg::SET_OFFICE_GND_BUSY;
      tcs_pkg::SET_STATION_LOOP_IDLE: d = tcs_pkg::SET_OFFICE_LOOP_IDLE;
      tcs_pkg::SET_STATION_LOOP_BUSY: d = tcs_pkg::SET_OFFICE_LOOP_BUSY;
      tcs_pkg::SET_OFFICE_DIAL_IDLE: d = tcs_pkg::SET_STATION_DIAL_IDLE;
      tcs_pkg::SET_OFFICE_DIAL_BUSY: d = tcs_pkg::SET_STATION_DIAL_BUSY;
      tcs_pkg::SET_STATION_DIAL_IDLE: d = tcs_pkg::SET_OFFICE_DIAL_IDLE;
      tcs_pkg::SET_STATION_DIAL_BUSY: d = tcs_pkg::SET_OFFICE_DIAL_BUSY;
      tcs_pkg::SET_ORIG_IDLE: d = tcs_pkg::SET_TERM_IDLE;
      tcs_pkg::SET_ORIG_BUSY: d = tcs_pkg::SET_TERM_BUSY;
      tcs_pkg::SET_TERM_IDLE: d = tcs_pkg::SET_ORIG_IDLE;
      tcs_pkg::SET_TERM_BUSY: d = tcs_pkg::SET_ORIG_BUSY;
      default: d = s;
    endcase
    return d;
  endfunction

  // ==========================================================
  // Alarm and idle timer per interface
  // ==========================================================
  logic [1:0] cga_reg, cga_next;
  logic [1:0] force_reg, force_next;
  logic [TW-1:0] tmr_reg [2];
  logic [TW-1:0] tmr_next [2];

  for (genvar g = 0; g < 2; g++) begin : g_line
    always_comb begin
      cga_next[g] = line_status[g].los | line_status[g].oof
                    | line_status[g].ais; // RL20
      if (!cga_reg[g]) begin
        tmr_next[g] = '0;
      end else if (tmr_reg[g] != IDLE_END) begin
        tmr_next[g] = tmr_reg[g] + 1'b1; // RL21
      end else begin
        tmr_next[g] = tmr_reg[g];
      end
      force_next[g] = cga_next[g] && (!cga_reg[g] || tmr_next[g] != IDLE_END);
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        cga_reg[g] <= 1'b0;
        force_reg[g] <= 1'b0;
        tmr_reg[g] <= '0;
      end else begin
        cga_reg[g] <= cga_next[g];
        force_reg[g] <= force_next[g];
        tmr_reg[g] <= tmr_next[g];
      end
    end
  end

  assign carrier_group_alarm = cga_reg;
  assign idle_forcing = force_reg;

  // ==========================================================
  // Input buffer and setting store
  // ==========================================================
  logic fifo_valid, fifo_pop;
  logic [SW-1:0] fifo_data;
  logic mem_we;
  logic [AW-1:0] mem_waddr, mem_raddr;
  tcs_pkg::tcs_entry_s mem_wdata, mem_rdata;

  tcs_fifo #(.W(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_sample),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // One entry per direction of every timeslot, addressed {dest, ts}.
  tcs_mem #(.W(EW), .AW(AW)) u_mem ( // RL25
    .clk(core_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Control sequencer
  // ==========================================================
  tcs_state_e state_reg, state_next;
  logic [AW-1:0] init_reg, init_next;
  tcs_pkg::tcs_cfg_s cfg_reg, cfg_next;
  tcs_pkg::tcs_sample_s smp_reg, smp_next;
  tcs_pkg::tcs_out_s out_reg, out_next;
  logic out_valid_reg, out_valid_next;
  logic cfg_ready_reg, cfg_ready_next;
  logic slot_free, cfg_take;

  assign slot_free = !out_valid_reg || out_ready;
  assign cfg_take = cfg_valid && cfg_ready_reg;
  assign fifo_pop = (state_reg == ST_IDLE) && !cfg_take && slot_free;
  assign out_valid = out_valid_reg;
  assign out_sample = out_reg;
  assign cfg_ready = cfg_ready_reg;

  always_comb begin
    logic src;
    logic [3:0] code;
    src = 1'b0;
    code = '0;
    state_next = state_reg;
    init_next = init_reg;
    cfg_next = cfg_reg;
    smp_next = smp_reg;
    out_next = out_reg;
    out_valid_next = out_valid_reg && !out_ready;
    mem_we = 1'b0;
    mem_waddr = init_reg;
    mem_wdata = tcs_pkg::ENTRY_RESET;
    mem_raddr = {fifo_data[SW-1], fifo_data[SW-2 -: tcs_pkg::TS_W]};
    case (state_reg)
      ST_INIT: begin
        // Fill every entry before buffered traffic is looked up or settings are accepted.
        mem_we = 1'b1; // RL24
        init_next = init_reg + 1'b1;
        if (init_reg == '1) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cfg_take) begin
          cfg_next = cfg;
          mem_raddr = {cfg.side, cfg.ts};
          state_next = ST_CFG_CHK;
        end else if (fifo_pop && fifo_valid) begin
          smp_next = fifo_data;
          state_next = ST_DATA;
        end
      end
      ST_CFG_CHK: begin
        mem_we = 1'b1;
        mem_waddr = {cfg_reg.side, cfg_reg.ts};
        mem_wdata = cfg_reg.entry;
        if (cfg_reg.side == tcs_pkg::SIDE_NET
            && mem_rdata.code == tcs_pkg::SET_NONE
            && cfg_reg.entry.code != tcs_pkg::SET_NONE) begin
          state_next = ST_CFG_DEF; // RL19
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_CFG_DEF: begin
        mem_we = 1'b1;
        mem_waddr = {tcs_pkg::SIDE_DSX, cfg_reg.ts};
        mem_wdata = cfg_reg.entry;
        mem_wdata.code = dsx_default(cfg_reg.entry.code); // RL18 RL19
        state_next = ST_IDLE;
      end
      ST_DATA: begin
        src = !smp_reg.dest;
        out_next.dest = smp_reg.dest;
        out_next.ts = smp_reg.ts;
        out_next.abcd = smp_reg.abcd;
        out_next.sig_used = mem_rdata.code != tcs_pkg::SET_NONE; // RL2
        out_next.conditioned = 1'b0;
        out_next.ab_only = 1'b0;
        if (out_next.sig_used) begin
          // Conditioning lasts exactly as long as the source alarm.
          if (mem_rdata.xconn && cga_reg[src]) begin // RL1 RL23
            if (mem_rdata.code == tcs_pkg::SET_USER) begin
              code = mem_rdata.user_abcd; // RL17 RL22
            end else begin
              code = cond_code(mem_rdata.code, force_reg[src]); // RL21
            end
            out_next.abcd = code;
            out_next.conditioned = 1'b1;
          end
          if (line_status[smp_reg.dest].d4) begin
            out_next.abcd = out_next.abcd & tcs_pkg::ABCD_AB_MASK; // RL5
            out_next.ab_only = 1'b1;
          end
        end
        out_valid_next = 1'b1; // RL3
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    cfg_ready_next = state_next == ST_IDLE && !(state_reg == ST_IDLE
                     && cfg_take);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_INIT;
      init_reg <= '0;
      cfg_reg <= '0;
      smp_reg <= '0;
      out_reg <= '0;
      out_valid_reg <= 1'b0;
      cfg_ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      init_reg <= init_next;
      cfg_reg <= cfg_next;
      smp_reg <= smp_next;
      out_reg <= out_next;
      out_valid_reg <= out_valid_next;
      cfg_ready_reg <= cfg_ready_next;
    end
  end
endmodule

// file: test/tcs_framer_model.sv
`timescale 1ns/1ps
// ==========================================================
// Framer pair model
// ==========================================================
module tcs_framer_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire tcs_pkg::tcs_line_s [1:0] line_req,
  input wire logic [1:0] ready_mode,
  output tcs_pkg::tcs_line_s [1:0] line_status,
  output logic out_ready
);
  logic toggle_reg;
  // Mode 1 stalls every other cycle so held outputs get exercised.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_status <= '0;
      toggle_reg <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      line_status <= line_req;
      toggle_reg <= ~toggle_reg;
      out_ready <= ready_mode == 2'h0 || (ready_mode == 2'h1 && toggle_reg);
    end
  end
endmodule

// file: test/tcs_signaling_props.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
// ==========================================================
module tcs_signaling_props #(
  parameter int COND_IDLE_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire tcs_pkg::tcs_line_s [1:0] line_status,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire tcs_pkg::tcs_out_s out_sample,
  input wire logic cfg_valid,
  input wire logic cfg_ready,
  input wire logic [1:0] carrier_group_alarm,
  input wire logic [1:0] idle_forcing
);
  localparam int IDLE_MAX = COND_IDLE_CYCLES + 2;
  logic [1:0] line_bad;
  assign line_bad = {|line_status[1][3:1], |line_status[0][3:1]};
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence cfg_taken;
    cfg_valid && cfg_ready;
  endsequence
  sequence alarm_rise;
    $rose(carrier_group_alarm[0]);
  endsequence
  alarm_follow_a: assert property (!$past(rst) |->
    carrier_group_alarm == $past(line_bad))
    else $error("alarm does not follow line faults");
  idle_start_a: assert property (alarm_rise |-> ##[0:1] idle_forcing[0])
    else $error("idle phase missing at alarm");
  idle_end_a: assert property ($rose(idle_forcing[0]) |->
    ##[1:IDLE_MAX] !idle_forcing[0])
    else $error("idle phase too long");
  out_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_sample))
    else $error("output changed while stalled");
  ab_only_a: assert property (out_valid && out_sample.ab_only |->
    out_sample.abcd[1:0] == 2'h0)
    else $error("C or D sent on D4 interface");
  clear_chan_a: assert property (out_valid && !out_sample.sig_used |->
    !out_sample.conditioned && !out_sample.ab_only)
    else $error("clear channel altered");
  // A plain write keeps ready low one cycle; a default load adds one more.
  cfg_gap_a: assert property (cfg_taken |=> !cfg_ready)
    else $error("config accepted too soon");
  cfg_back_a: assert property (cfg_taken |-> ##[2:3] cfg_ready)
    else $error("config ready not restored");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=>
    !out_valid && !cfg_ready && !in_ready)
    else $error("outputs active in reset");
endmodule
bind tcs_signaling tcs_signaling_props #(
  .COND_IDLE_CYCLES(COND_IDLE_CYCLES)
) props_i (
  .core_clk(core_clk),
  .rst(rst),
  .line_status(line_status),
  .in_ready(in_ready),
  .out_valid(out_valid),
  .out_ready(out_ready),
  .out_sample(out_sample),
  .cfg_valid(cfg_valid),
  .cfg_ready(cfg_ready),
  .carrier_group_alarm(carrier_group_alarm),
  .idle_forcing(idle_forcing)
);

// file: test/tcs_signaling_tb_top.sv
`timescale 1ns/1ps
module tcs_signaling_tb_top;
  localparam int COND = 400;
  localparam int LIM = 2000;
  logic core_clk, rst, in_valid, in_ready, out_valid, out_ready;
  logic cfg_valid, cfg_ready;
  logic [1:0] ready_mode, carrier_group_alarm, idle_forcing;
  tcs_pkg::tcs_line_s [1:0] line_req, line_status;
  tcs_pkg::tcs_sample_s in_sample;
  tcs_pkg::tcs_out_s out_sample;
  tcs_pkg::tcs_cfg_s cfg;
  tcs_pkg::tcs_out_s exp_q[$];
  int miscompares, tests_run, n, k;
  // Alarm codes in setting order, idle then busy.
  logic [3:0] sel_tab [24] = '{4'h0, 4'hf,
    4'h0, 4'hf, 4'hf, 4'h5, 4'h5, 4'h5,
    4'h5, 4'hf, 4'h5, 4'hf, 4'h0, 4'hf,
    4'h0, 4'hf, 4'h0, 4'hf, 4'hf, 4'h0,
    4'h0, 4'hf, 4'h0, 4'hf};

  tcs_signaling #(.COND_IDLE_CYCLES(COND)) uut (
    .core_clk(core_clk), .rst(rst), .line_status(line_status),
    .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample),
    .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg(cfg),
    .carrier_group_alarm(carrier_group_alarm), .idle_forcing(idle_forcing));
  tcs_framer_model far_i (.core_clk(core_clk), .rst(rst),
    .line_req(line_req), .ready_mode(ready_mode),
    .line_status(line_status), .out_ready(out_ready));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task complete_run;
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task miss(input string m);
    miscompares++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task cmp_out(input tcs_pkg::tcs_out_s got, input tcs_pkg::tcs_out_s exp);
    tests_run++;
    if (got !== exp) miss($sformatf("sample %h want %h", got, exp));
  endtask
  task cmp_flag(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) miss($sformatf("flags %b want %b", got, exp));
  endtask
  task bail(input int c);
    if (c >= LIM) begin
      miss("wait ran out");
      complete_run();
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  // The flags argument is {sig_used, conditioned, ab_only}.
  task put(input logic d, input int t, input logic [3:0] a,
    input logic [3:0] e, input logic [2:0] f);
    int c;
    tick(1);
    in_sample = '{d, t[4:0], a};
    in_valid = 1'b1;
    exp_q.push_back({d, t[4:0], e, f});
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (in_ready !== 1'b1 && c < LIM);
    bail(c);
    #1;
    in_valid = 1'b0;
  endtask
  task set_cfg(input logic s, input int t, input logic x,
    input tcs_pkg::tcs_setting_e m, input logic [3:0] u);
    int c;
    tick(1);
    cfg = '{s, t[4:0], '{x, m, u}};
    cfg_valid = 1'b1;
    for (c = 0; c < 2; c++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (cfg_ready !== 1'b1 && n < LIM);
      bail(n);
      #1;
      cfg_valid = 1'b0;
    end
  endtask
  task wait_if(input int s, input logic v);
    n = 0;
    while (idle_forcing[s] !== v && n < LIM) begin
      tick(1);
      n++;
    end
    bail(n);
  endtask
  // Alarm and framing changes must wait until queued lookups are done.
  task drain;
    n = 0;
    while (exp_q.size() != 0 && n < LIM) begin
      tick(1);
      n++;
    end
    bail(n);
    tick(2);
  endtask

  always @(posedge core_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) miss("extra sample");
      else cmp_out(out_sample, exp_q.pop_front());
    end
  end

  initial begin
    miscompares = 0;
    tests_run = 0;
    rst = 1'b1;
    in_valid = 1'b0;
    cfg_valid = 1'b0;
    ready_mode = 2'h0;
    line_req = '0;
    in_sample = '0;
    cfg = '0;
    tick(3);
    rst = 1'b0;
    n = 0;
    while (cfg_ready !== 1'b1 && n < LIM) begin
      tick(1);
      n++;
    end
    bail(n);
    cmp_flag({in_ready, cfg_ready}, 2'h3);
    put(1'b1, 3, 4'h9, 4'h9, 3'h4);
    drain();
    for (k = 0; k < 3; k++) begin
      line_req[0] = 4'h8 >> k;
      tick(3);
      cmp_flag(carrier_group_alarm, 2'h1);
      if (k == 0) put(1'b1, 3, 4'h9, 4'h9, 3'h4);
      drain();
      line_req[0] = '0;
      tick(3);
      cmp_flag(carrier_group_alarm, 2'h0);
    end
    set_cfg(1'b1, 0, 1'b1, tcs_pkg::SET_NONE, 4'h0);
    for (k = 1; k < 25; k++)
      set_cfg(1'b1, k, 1'b1, tcs_pkg::tcs_setting_e'(k), 4'ha);
    ready_mode = 2'h1;
    line_req[0].los = 1'b1;
    wait_if(0, 1'b1);
    put(1'b1, 24, 4'h6, 4'ha, 3'h6);
    put(1'b1, 3, 4'h6, 4'h0, 3'h6);
    put(1'b1, 0, 4'h6, 4'h6, 3'h0);
    drain();
    wait_if(0, 1'b0);
    for (k = 1; k < 25; k++)
      put(1'b1, k, 4'h6, k == 24 ? 4'ha : sel_tab[k], 3'h6);
    drain();
    line_req[1].d4 = 1'b1;
    tick(3);
    put(1'b1, 3, 4'h6, 4'hc, 3'h7);
    drain();
    line_req[0].los = 1'b0;
    tick(3);
    put(1'b1, 3, 4'h7, 4'h4, 3'h5);
    drain();
    line_req[1].d4 = 1'b0;
    set_cfg(1'b0, 25, 1'b1, tcs_pkg::SET_NONE, 4'h0);
    set_cfg(1'b0, 25, 1'b1, tcs_pkg::SET_OFFICE_GND_BUSY, 4'h0);
    line_req[0].los = 1'b1;
    line_req[1].ais = 1'b1;
    wait_if(0, 1'b1);
    wait_if(0, 1'b0);
    wait_if(1, 1'b0);
    put(1'b1, 25, 4'h6, 4'hf, 3'h6);
    put(1'b0, 25, 4'h6, 4'h5, 3'h6);
    drain();
    line_req = '0;
    tick(3);
    ready_mode = 2'h2;
    k = 0;
    while (in_ready === 1'b1 && k < 40) begin
      put(1'b0, k, k[3:0], k[3:0], 3'h4);
      k++;
    end
    cmp_flag({k >= 16, in_ready}, 2'h2);
    ready_mode = 2'h1;
    drain();
    complete_run();
  end
endmodule
